// ===== gdc_pkg.sv
// Purpose: shared constants for the pin and datapath configuration bank
// Assumes: apb with 8-bit byte address, 32-bit data, one word per register
// Notes: register index times four gives the byte address
package gdc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_PINS = 4;
    localparam int FWD_W = 7;

    // register indexes; byte address is index * 4
    localparam logic [5:0] IDX_PINS_5_6 = 6'h20;
    localparam logic [5:0] IDX_PINS_7_8 = 6'h21;
    localparam logic [5:0] IDX_PATH_CTL = 6'h22;
    localparam logic [5:0] IDX_PIN_STATUS = 6'h30;

    localparam logic [REG_W-1:0] RST_PINS_5_6 = 8'h00;
    localparam logic [REG_W-1:0] RST_PINS_7_8 = 8'h00;
    localparam logic [REG_W-1:0] RST_PATH_CTL = 8'h00;
    // pin 7/8 bit 0 is reserved and reads as zero
    localparam logic [REG_W-1:0] MASK_PINS_7_8 = 8'hfe;

    // per-pin field offsets inside a nibble
    localparam int FLD_LOCAL_OUT = 3;
    localparam int FLD_REMOTE_CTL = 2;
    localparam int FLD_DIRECTION = 1;
    localparam int FLD_FUNC_ENABLE = 0;
    localparam int NIB_HI = 4;
    localparam int NIB_LO = 0;

    // datapath control bits
    localparam int BIT_BLOCK_FWD = 7;
    localparam int BIT_PASSTHRU = 6;
    localparam int BIT_VALID_POL = 5;
    localparam int BIT_SUPPRESS_AUD = 4;
    localparam int BIT_QUAD_OVR = 3;
    localparam int BIT_WIDTH_18 = 2;
    localparam int BIT_TRANSPORT = 1;
    localparam int BIT_QUAD_EN = 0;

    // direction/enable code, direction bit on the left
    localparam logic [1:0] CODE_FUNC_OUT = 2'b00;
    localparam logic [1:0] CODE_GP_OUT = 2'b01;
    localparam logic [1:0] CODE_TRISTATE = 2'b10;
    localparam logic [1:0] CODE_GP_IN = 2'b11;

    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        GDC_ST_IDLE = 2'b01,
        GDC_ST_ACCESS = 2'b10
    } gdc_apb_e;
endpackage : gdc_pkg

// ===== gdc_pin_ctl.sv
// Purpose: one general-purpose pin: mode decode and registered pad drive
// Assumes: pin input and remote value synchronous to sys_clk
// Notes: output enable is active low
`timescale 1ns/1ns
module gdc_pin_ctl
    import gdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // configuration
    input wire logic local_out,
    input wire logic remote_ctl,
    input wire logic direction,
    input wire logic func_enable,
    // value sources
    input wire logic remote_val,
    input wire logic func_val,
    input wire logic pin_in,
    // pad side
    output logic pin_out,
    output logic pin_oe_n,
    output logic pin_level
);
    logic [1:0] mode_code;
    logic next_pin_out;
    logic next_pin_oe_n;
    logic next_pin_level;

    assign mode_code = {direction, func_enable};

    always_comb begin
        next_pin_level = pin_in;
        if (remote_ctl) begin
            next_pin_out = remote_val;
            next_pin_oe_n = 1'b0;
        end else begin
            case (mode_code)
                CODE_FUNC_OUT: begin
                    next_pin_out = func_val;
                    next_pin_oe_n = 1'b0;
                end
                CODE_GP_OUT: begin
                    next_pin_out = local_out;
                    next_pin_oe_n = 1'b0;
                end
                default: begin
                    next_pin_out = 1'b0;
                    next_pin_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            pin_level <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            pin_level <= next_pin_level;
        end
    end

    remote_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        remote_ctl |=> (!pin_oe_n && pin_out == $past(remote_val)))
        else $error("remote pin not driven with remote value");
    local_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!remote_ctl && !direction && func_enable) |=> (!pin_oe_n && pin_out == $past(local_out)))
        else $error("local output value not driven");
    tristate_code_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!remote_ctl && direction) |=> pin_oe_n)
        else $error("tri-state or input code still drives pin");
endmodule : gdc_pin_ctl

// ===== gdc_config_regs.sv
// Purpose: apb register bank for pins 5-8 and video/audio datapath control
// Assumes: apb slave, no wait states; remote inputs synchronous to sys_clk
// Notes: registers at byte address index*4; unmapped access gives pslverr
`timescale 1ns/1ns
module gdc_config_regs
    import gdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gdc_pkg::ADDR_W-1:0] paddr,
    input wire logic [gdc_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [gdc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // remote serializer side
    input wire logic [gdc_pkg::NUM_PINS-1:0] remote_pin_val,
    input wire logic fwd_load,
    input wire logic [gdc_pkg::FWD_W-1:0] fwd_ctl_data,
    // pads, index 0 is pin 5
    input wire logic [gdc_pkg::NUM_PINS-1:0] pin_in,
    input wire logic [gdc_pkg::NUM_PINS-1:0] func_val,
    output logic [gdc_pkg::NUM_PINS-1:0] pin_out,
    output logic [gdc_pkg::NUM_PINS-1:0] pin_oe_n,
    // pixel data valid path
    input wire logic link_data_valid,
    output logic pixel_data_valid,
    output logic pixel_accept,
    // datapath settings
    output logic protect_allow,
    output logic packet_audio_allow,
    output logic audio_on_pixels,
    output logic width_18bit,
    output logic transport_inband,
    output logic quad_audio_en
);
    gdc_apb_e state;
    gdc_apb_e next_state;
    logic [REG_W-1:0] pins_5_6_config;
    logic [REG_W-1:0] pins_7_8_config;
    logic [REG_W-1:0] video_audio_path_control;
    logic [REG_W-1:0] next_pins_5_6_config;
    logic [REG_W-1:0] next_pins_7_8_config;
    logic [REG_W-1:0] next_path_ctl;
    logic [DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [NUM_PINS-1:0] pin_level;
    logic [REG_W-1:0] pin_status;
    logic [5:0] acc_idx;
    logic acc_aligned;
    logic acc_hit;
    logic [REG_W-1:0] rd_val;
    logic wr_fire;
    logic [15:0] pin_fields;

    // per-pin nibbles: pins 5,6 from 5/6 register, pins 7,8 from 7/8 register
    assign pin_fields = {pins_7_8_config, pins_5_6_config};
    assign acc_idx = paddr[ADDR_W-1:2];
    assign acc_aligned = (paddr[1:0] == 2'b00);
    assign pin_status = {~pin_oe_n, pin_level};

    // address decode
    always_comb begin
        rd_val = 8'h00;
        acc_hit = acc_aligned;
        if (acc_idx == IDX_PINS_5_6) begin
            rd_val = pins_5_6_config;
        end else if (acc_idx == IDX_PINS_7_8) begin
            rd_val = pins_7_8_config & MASK_PINS_7_8;
        end else if (acc_idx == IDX_PATH_CTL) begin
            rd_val = video_audio_path_control;
        end else if (acc_idx == IDX_PIN_STATUS) begin
            rd_val = pin_status;
            acc_hit = acc_aligned && !pwrite;
        end else begin
            acc_hit = 1'b0;
        end
    end

    assign wr_fire = (state == GDC_ST_ACCESS) && psel && penable && pwrite && acc_hit && pstrb[0];

    // apb handshake: setup cycle arms a one-cycle pready in the access phase
    always_comb begin
        next_state = state;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        case (state)
            GDC_ST_IDLE: begin
                if (psel && !penable) begin
                    next_state = GDC_ST_ACCESS;
                    next_pready = 1'b1;
                    next_pslverr = !acc_hit;
                    next_prdata = (!pwrite && acc_hit) ? {24'h00_0000, rd_val} : ZERO_WORD;
                end
            end
            GDC_ST_ACCESS: begin
                next_state = GDC_ST_IDLE;
                next_prdata = ZERO_WORD;
            end
            default: begin
                next_state = GDC_ST_IDLE;
            end
        endcase
    end

    // register contents; a software write in the same cycle wins over the link
    always_comb begin
        next_pins_5_6_config = pins_5_6_config;
        next_pins_7_8_config = pins_7_8_config;
        next_path_ctl = video_audio_path_control;
        if (fwd_load && !video_audio_path_control[BIT_BLOCK_FWD]) begin
            next_path_ctl[FWD_W-1:0] = fwd_ctl_data;
        end
        if (wr_fire) begin
            if (acc_idx == IDX_PINS_5_6) begin
                next_pins_5_6_config = pwdata[REG_W-1:0];
            end else if (acc_idx == IDX_PINS_7_8) begin
                next_pins_7_8_config = pwdata[REG_W-1:0] & MASK_PINS_7_8;
            end else if (acc_idx == IDX_PATH_CTL) begin
                next_path_ctl = pwdata[REG_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= GDC_ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= ZERO_WORD;
            pins_5_6_config <= RST_PINS_5_6;
            pins_7_8_config <= RST_PINS_7_8;
            video_audio_path_control <= RST_PATH_CTL;
        end else begin
            state <= next_state;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            pins_5_6_config <= next_pins_5_6_config;
            pins_7_8_config <= next_pins_7_8_config;
            video_audio_path_control <= next_path_ctl;
        end
    end

    // one controller per pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            gdc_pin_ctl u_pin (
                .sys_clk(sys_clk),
                .arst_n(arst_n),
                .local_out(pin_fields[gi*4+FLD_LOCAL_OUT]),
                .remote_ctl(pin_fields[gi*4+FLD_REMOTE_CTL]),
                .direction(pin_fields[gi*4+FLD_DIRECTION]),
                .func_enable(pin_fields[gi*4+FLD_FUNC_ENABLE]),
                .remote_val(remote_pin_val[gi]),
                .func_val(func_val[gi]),
                .pin_in(pin_in[gi]),
                .pin_out(pin_out[gi]),
                .pin_oe_n(pin_oe_n[gi]),
                .pin_level(pin_level[gi])
            );
        end
    endgenerate

    // datapath settings decode, registered onto the outputs
    logic passthru;
    logic next_pixel_data_valid;
    logic next_pixel_accept;
    logic next_protect_allow;
    logic next_packet_audio_allow;
    logic next_audio_on_pixels;
    logic next_width_18bit;
    logic next_transport_inband;
    logic next_quad_audio_en;

    assign passthru = video_audio_path_control[BIT_PASSTHRU];

    always_comb begin
        // polarity 1: active low, idle high
        next_pixel_data_valid = link_data_valid ^ video_audio_path_control[BIT_VALID_POL];
        next_pixel_accept = passthru || link_data_valid;
        next_protect_allow = !passthru;
        next_packet_audio_allow = !passthru;
        next_audio_on_pixels = !passthru && !video_audio_path_control[BIT_SUPPRESS_AUD];
        next_width_18bit = video_audio_path_control[BIT_WIDTH_18];
        next_transport_inband = video_audio_path_control[BIT_TRANSPORT];
        next_quad_audio_en = video_audio_path_control[BIT_QUAD_OVR]
            && video_audio_path_control[BIT_QUAD_EN];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pixel_data_valid <= 1'b0;
            pixel_accept <= 1'b0;
            protect_allow <= 1'b0;
            packet_audio_allow <= 1'b0;
            audio_on_pixels <= 1'b0;
            width_18bit <= 1'b0;
            transport_inband <= 1'b0;
            quad_audio_en <= 1'b0;
        end else begin
            pixel_data_valid <= next_pixel_data_valid;
            pixel_accept <= next_pixel_accept;
            protect_allow <= next_protect_allow;
            packet_audio_allow <= next_packet_audio_allow;
            audio_on_pixels <= next_audio_on_pixels;
            width_18bit <= next_width_18bit;
            transport_inband <= next_transport_inband;
            quad_audio_en <= next_quad_audio_en;
        end
    end

    fwd_blocked_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (video_audio_path_control[BIT_BLOCK_FWD] && !wr_fire)
        |=> $stable(video_audio_path_control))
        else $error("path control changed while link loading blocked");
    fwd_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (fwd_load && !video_audio_path_control[BIT_BLOCK_FWD] && !wr_fire)
        |=> video_audio_path_control[FWD_W-1:0] == $past(fwd_ctl_data))
        else $error("link value not loaded into path control");
    passthru_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        passthru |=> pixel_accept)
        else $error("passthrough did not accept pixels");
    passthru_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        passthru |=> (!protect_allow && !packet_audio_allow && !audio_on_pixels))
        else $error("passthrough left protection or audio enabled");
    valid_pol_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> pixel_data_valid
            == ($past(link_data_valid) ^ $past(video_audio_path_control[BIT_VALID_POL])))
        else $error("data valid polarity wrong");
    quad_audio_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !video_audio_path_control[BIT_QUAD_OVR] |=> !quad_audio_en)
        else $error("four-channel audio on without override bit");
    rsv_bit_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !pins_7_8_config[0])
        else $error("reserved bit set in pin 7/8 register");
    apb_ready_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (psel && !penable && state == GDC_ST_IDLE) |=> (pready ##1 !pready))
        else $error("apb answer not one-cycle pready");

    // decode and register-write checks
    suppress_audio_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        video_audio_path_control[BIT_SUPPRESS_AUD] |=> !audio_on_pixels)
        else $error("packet audio on pixels while suppressed");
    audio_pixels_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!passthru && !video_audio_path_control[BIT_SUPPRESS_AUD]) |=> audio_on_pixels)
        else $error("packet audio missing from pixels");
    pixel_framing_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!passthru && !link_data_valid) |=> !pixel_accept)
        else $error("pixels accepted without data valid");
    protect_on_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !passthru |=> (protect_allow && packet_audio_allow))
        else $error("protection or packet audio blocked without passthrough");
    width_sel_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> width_18bit == $past(video_audio_path_control[BIT_WIDTH_18]))
        else $error("pixel width select not followed");
    transport_sel_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> transport_inband == $past(video_audio_path_control[BIT_TRANSPORT]))
        else $error("audio transport select not followed");
    quad_enable_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !video_audio_path_control[BIT_QUAD_EN] |=> !quad_audio_en)
        else $error("four-channel audio on with enable bit clear");
    quad_on_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (video_audio_path_control[BIT_QUAD_OVR] && video_audio_path_control[BIT_QUAD_EN])
        |=> quad_audio_en)
        else $error("four-channel audio not taken from enable bit");
    pins_56_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_fire && acc_idx == IDX_PINS_5_6) |=> pins_5_6_config == $past(pwdata[REG_W-1:0]))
        else $error("pin 5/6 write not stored");
    pins_78_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_fire && acc_idx == IDX_PINS_7_8)
        |=> pins_7_8_config == ($past(pwdata[REG_W-1:0]) & MASK_PINS_7_8))
        else $error("pin 7/8 write not stored");
    write_wins_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wr_fire && acc_idx == IDX_PATH_CTL)
        |=> video_audio_path_control == $past(pwdata[REG_W-1:0]))
        else $error("software write to path control lost");
endmodule : gdc_config_regs

// ===== gdc_remote_ser.sv
// Purpose: remote serializer stand-in driving pin values and link loads
// Assumes: outputs change just after a rising sys_clk edge
// Notes: link data shows the inverse of the last value outside a load
`timescale 1ns/1ns
module gdc_remote_ser
    import gdc_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // link side
    output logic [gdc_pkg::NUM_PINS-1:0] remote_pin_val,
    output logic fwd_load,
    output logic [gdc_pkg::FWD_W-1:0] fwd_ctl_data
);
    initial begin
        remote_pin_val = 4'h0;
        fwd_load = 1'b0;
        fwd_ctl_data = 7'h00;
    end

    task automatic set_pins(input logic [NUM_PINS-1:0] v);
        @(posedge sys_clk);
        remote_pin_val <= v;
    endtask : set_pins

    // one-cycle load pulse after gap idle cycles
    task automatic send_load(input logic [FWD_W-1:0] d, input int gap);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        fwd_load <= 1'b1;
        fwd_ctl_data <= d;
        @(posedge sys_clk);
        fwd_load <= 1'b0;
        fwd_ctl_data <= ~d;
    endtask : send_load
endmodule : gdc_remote_ser

// ===== gdc_config_regs_tb.sv
// Purpose: self-checking bench for the pin and datapath configuration bank
// Assumes: apb master tasks, remote serializer model on the link side
// Notes: outputs are sampled two edges after their cause has been applied
`timescale 1ns/1ns
module gdc_config_regs_tb;
    import gdc_pkg::*;
    logic sys_clk, arst_n, psel, penable, pwrite, link_data_valid, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb, pin_in, func_val, pin_out, pin_oe_n, remote_pin_val;
    logic fwd_load, err, pixel_data_valid, pixel_accept, protect_allow;
    logic packet_audio_allow, audio_on_pixels, width_18bit, transport_inband, quad_audio_en;
    logic [FWD_W-1:0] fwd_ctl_data, d;
    logic [7:0] b, exp8, outs;
    logic [1:0] c;
    logic [6:0] tbl [6] = '{7'h7f, 7'h2a, 7'h09, 7'h01, 7'h10, 7'h00};
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    assign outs = {pixel_data_valid, pixel_accept, protect_allow, packet_audio_allow,
        audio_on_pixels, width_18bit, transport_inband, quad_audio_en};

    gdc_config_regs gdc_config_regs_inst (.sys_clk, .arst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .remote_pin_val, .fwd_load,
        .fwd_ctl_data, .pin_in, .func_val, .pin_out, .pin_oe_n, .link_data_valid,
        .pixel_data_valid, .pixel_accept, .protect_allow, .packet_audio_allow,
        .audio_on_pixels, .width_18bit, .transport_inband, .quad_audio_en);

    gdc_remote_ser gdc_remote_ser_inst (.sys_clk, .remote_pin_val, .fwd_load, .fwd_ctl_data);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; answer taken at the edge where pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            input logic [3:0] s);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 4'hf);
    endtask : wr

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, ZERO_WORD, 4'hf);
        check(what, rd, exp);
    endtask : rdchk

    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = ZERO_WORD;
        pstrb = 4'h0;
        pin_in = 4'h9;
        func_val = 4'h2;
        link_data_valid = 1'b0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        rdchk("pins_5_6 reset", 8'h80, ZERO_WORD);
        rdchk("pins_7_8 reset", 8'h84, ZERO_WORD);
        rdchk("path reset", 8'h88, ZERO_WORD);
        check("oe after reset", pin_oe_n, 4'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            c = i[1:0];
            b = {~i[2], 1'b0, c, i[2], 1'b0, c};
            wr(8'h80, {24'h00_0000, b});
            rdchk("pins_5_6 readback", 8'h80, {24'h00_0000, b});
            settle();
            check("oe pins 5 6", pin_oe_n[1:0], {2{c[1]}});
            exp8 = c[0] ? {6'h00, ~i[2], i[2]} : {6'h00, func_val[1:0]};
            if (!c[1]) check("out pins 5 6", pin_out[1:0], exp8);
        end
        $display("test pin modes done");
        wr(8'h84, 32'h0000_0077);
        rdchk("pins_7_8 reserved", 8'h84, 32'h0000_0076);
        wr(8'h80, 32'h0000_000f);
        for (int j = 0; j < 2; j++) begin
            b = j[0] ? 8'h05 : 8'h0a;
            gdc_remote_ser_inst.set_pins(b[3:0]);
            settle();
            check("remote oe", pin_oe_n, 4'h0);
            check("remote out", {pin_out[3:2], pin_out[0]}, {b[3:2], b[0]});
        end
        wr(8'h84, 32'h0000_0033);
        settle();
        check("remote off oe", pin_oe_n[3:2], 2'b11);
        rdchk("status", 8'hc0, 32'h0000_0039);
        $display("test remote pins done");
        apb(1'b1, 8'hc0, 32'h0000_00ff, 4'hf);
        check("status write err", err, 1'b1);
        apb(1'b0, 8'h8c, ZERO_WORD, 4'hf);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, ZERO_WORD);
        apb(1'b0, 8'h81, ZERO_WORD, 4'hf);
        check("misaligned err", err, 1'b1);
        apb(1'b1, 8'h88, 32'hffff_ff55, 4'he);
        rdchk("strobe off", 8'h88, ZERO_WORD);
        $display("test refusals done");
        foreach (tbl[k]) begin
            d = tbl[k];
            gdc_remote_ser_inst.send_load(d, k);
            rdchk("path load", 8'h88, {25'h000_0000, d});
            for (int l = 0; l < 2; l++) begin
                @(posedge sys_clk);
                link_data_valid <= l[0];
                settle();
                exp8 = {l[0] ^ d[5], d[6] | l[0], !d[6], !d[6], !d[6] & !d[4], d[2], d[1],
                    d[3] & d[0]};
                check("path outs", outs, exp8);
            end
        end
        wr(8'h88, 32'h0000_0084);
        gdc_remote_ser_inst.send_load(7'h7b, 0);
        rdchk("path held", 8'h88, 32'h0000_0084);
        wr(8'h88, ZERO_WORD);
        gdc_remote_ser_inst.send_load(7'h55, 0);
        rdchk("path loaded", 8'h88, 32'h0000_0055);
        $display("test datapath done");
        complete_run();
    end
endmodule : gdc_config_regs_tb
